// *** hw/port_d_mux_pkg.sv ***
// Constants shared by the port D alternate function mux
package port_d_mux_pkg;
    localparam int PIN_COUNT = 7;
    localparam int PIN_EXT_IRQ = 6;
    localparam int PIN_SPARE5 = 5;
    localparam int PIN_RX_SCK = 4;
    localparam int PIN_TX_MOSI = 3;
    localparam int PIN_MISO = 2;
    localparam int PIN_CLK_OUT = 1;
    localparam int PIN_SPARE0 = 0;
    localparam logic [6:0] DIR_RESET = 7'h00;
    localparam logic [6:0] OUT_RESET = 7'h00;
    localparam logic [6:0] PULL_RESET = 7'h00;
    typedef enum logic [1:0] {
        SPI_OFF,
        SPI_SLAVE,
        SPI_MASTER
    } spi_role_type;
endpackage

// *** hw/pin_override_cell.sv ***
// One pin cell: applies a peripheral override or the ordinary port values
`timescale 1ns/10ps
module pin_override_cell (
    input wire logic portDir, // Ordinary direction bit
    input wire logic portOut, // Ordinary output bit
    input wire logic pullUpAllowed, // Global pull-up permission
    input wire logic dirOverrideEn, // Direction override enable
    input wire logic dirOverrideVal, // Direction override value
    input wire logic valOverrideEn, // Value override enable
    input wire logic valOverrideVal, // Value override value
    input wire logic pullOverrideEn, // Pull-up override enable
    input wire logic pullOverrideVal, // Pull-up override value
    output logic pinDrive, // Output enable of the pin
    output logic pinValue, // Output level of the pin
    output logic pinPullUp // Pull-up enable
);
    always_comb begin
        pinDrive = dirOverrideEn ? dirOverrideVal : portDir;
        pinValue = valOverrideEn ? valOverrideVal : portOut;
        if (pullOverrideEn) begin
            pinPullUp = pullOverrideVal;
        end else begin
            pinPullUp = ~portDir & portOut & pullUpAllowed;
        end
    end
endmodule

// *** hw/port_d_alternate_function_mux.sv ***
// Port D pins 6..0: peripheral overrides of direction, value and pull-up
`timescale 1ns/10ps
// Notes on behaviour
// - Receiver enabled forces pin 4 to input.
// - Receiver-held pin 4 gets pull-up when its output bit is one.
// - SPI slave forces clock pin 4 input; master follows direction bit.
// - SPI-forced pin 4 input keeps pull-up under its output bit.
// - Transmitter enabled drives pin 3 as output with transmit data.
// - SPI slave uses pin 3 as slave select, active low.
// - Pin 3 data is input for slave, direction bit for master.
// - SPI-forced pin 3 input keeps pull-up under its output bit.
// - Pin 2 input for master, direction bit for slave, pull-up kept.
// - Clock output option drives divided clock on pin 1, overriding bits.
// - Divided clock stays on pin 1 during reset.
// - Pin 6 feeds external interrupt 0; input kept enabled when enabled.
module port_d_alternate_function_mux
    import port_d_mux_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [6:0] portDirBits, // Ordinary direction bits
    input wire logic [6:0] portOutBits, // Ordinary output bits
    input wire logic [6:0] pinInput, // Pin levels, synchronous
    input wire logic pullUpDisable, // Global pull-up disable
    input wire logic receiverEnable, // Serial receiver enable
    input wire logic transmitterEnable, // Serial transmitter enable
    input wire logic transmitData, // Serial transmit data
    input wire logic spiEnable, // SPI enable
    input wire logic spiMaster, // SPI is master
    input wire logic spiPinSelect, // SPI on these alternate pins
    input wire logic spiClockOut, // SPI master clock
    input wire logic spiMosiOut, // SPI master data out
    input wire logic spiMisoOut, // SPI slave data out
    input wire logic timer0CompareEn, // Timer 0 compare A output enable
    input wire logic timer0CompareA, // Timer 0 compare A level
    input wire logic timer1CompareEn, // Timer 1 compare A output enable
    input wire logic timer1CompareA, // Timer 1 compare A level
    input wire logic clockOutputOption, // Divided clock output option
    input wire logic dividedClock, // Divided system clock
    input wire logic extIrqZeroEnable, // External interrupt 0 enable
    input wire logic adc3DigitalOff, // Digital input off on pin 6
    output logic [6:0] pinDrive, // Pin output enables
    output logic [6:0] pinValue, // Pin output levels
    output logic [6:0] pinPullUp, // Pin pull-up enables
    output logic serialReceiveData, // Registered receive data
    output logic spiClockIn, // Registered SPI slave clock
    output logic spiSlaveSelect, // Registered slave select, low active
    output logic spiMosiIn, // Registered slave data in
    output logic spiMisoIn, // Registered master data in
    output logic timer1CaptureIn, // Registered capture input
    output logic externalIrqZero, // Registered external interrupt 0
    output logic spiSlaveActive // Slave selected and enabled
);
    import port_d_mux_pkg::*;

    spi_role_type spiRole;
    logic spiOnPins;
    logic pin6InputOn;
    logic [6:0] dirOvEn, dirOvVal, valOvEn, valOvVal, pullOvEn, pullOvVal;
    logic [6:0] cellDrive, cellValue, cellPull;

    always_comb begin
        spiOnPins = spiEnable & spiPinSelect;
        if (!spiOnPins) begin
            spiRole = SPI_OFF;
        end else if (spiMaster) begin
            spiRole = SPI_MASTER;
        end else begin
            spiRole = SPI_SLAVE;
        end
        pin6InputOn = extIrqZeroEnable | ~adc3DigitalOff;
    end

    always_comb begin
        dirOvEn = 7'h00;
        dirOvVal = 7'h00;
        valOvEn = 7'h00;
        valOvVal = 7'h00;
        pullOvEn = 7'h00;
        pullOvVal = 7'h00;
        // Pin 4: receiver first, then SPI clock
        if (receiverEnable) begin
            dirOvEn[PIN_RX_SCK] = 1'b1;
            pullOvEn[PIN_RX_SCK] = 1'b1;
            pullOvVal[PIN_RX_SCK] = portOutBits[PIN_RX_SCK] & ~pullUpDisable;
        end else begin
            case (spiRole)
                SPI_SLAVE: begin
                    dirOvEn[PIN_RX_SCK] = 1'b1;
                    pullOvEn[PIN_RX_SCK] = 1'b1;
                    pullOvVal[PIN_RX_SCK] = portOutBits[PIN_RX_SCK] & ~pullUpDisable;
                end
                SPI_MASTER: begin
                    valOvEn[PIN_RX_SCK] = 1'b1;
                    valOvVal[PIN_RX_SCK] = spiClockOut;
                end
                default: begin
                end
            endcase
        end
        // Pin 3: transmitter, then SPI, then timer 0
        if (transmitterEnable) begin
            dirOvEn[PIN_TX_MOSI] = 1'b1;
            dirOvVal[PIN_TX_MOSI] = 1'b1;
            valOvEn[PIN_TX_MOSI] = 1'b1;
            valOvVal[PIN_TX_MOSI] = transmitData;
            pullOvEn[PIN_TX_MOSI] = 1'b1;
        end else begin
            case (spiRole)
                SPI_SLAVE: begin
                    dirOvEn[PIN_TX_MOSI] = 1'b1;
                    pullOvEn[PIN_TX_MOSI] = 1'b1;
                    pullOvVal[PIN_TX_MOSI] = portOutBits[PIN_TX_MOSI] & ~pullUpDisable;
                end
                SPI_MASTER: begin
                    valOvEn[PIN_TX_MOSI] = 1'b1;
                    valOvVal[PIN_TX_MOSI] = spiMosiOut;
                end
                default: begin
                    valOvEn[PIN_TX_MOSI] = timer0CompareEn;
                    valOvVal[PIN_TX_MOSI] = timer0CompareA;
                end
            endcase
        end
        // Pin 2: SPI data in/out, then timer 1
        case (spiRole)
            SPI_MASTER: begin
                dirOvEn[PIN_MISO] = 1'b1;
                pullOvEn[PIN_MISO] = 1'b1;
                pullOvVal[PIN_MISO] = portOutBits[PIN_MISO] & ~pullUpDisable;
            end
            SPI_SLAVE: begin
                valOvEn[PIN_MISO] = 1'b1;
                valOvVal[PIN_MISO] = spiMisoOut;
            end
            default: begin
                valOvEn[PIN_MISO] = timer1CompareEn;
                valOvVal[PIN_MISO] = timer1CompareA;
            end
        endcase
        // Pin 1: divided clock, independent of reset
        if (clockOutputOption) begin
            dirOvEn[PIN_CLK_OUT] = 1'b1;
            dirOvVal[PIN_CLK_OUT] = 1'b1;
            valOvEn[PIN_CLK_OUT] = 1'b1;
            valOvVal[PIN_CLK_OUT] = dividedClock;
            pullOvEn[PIN_CLK_OUT] = 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            pin_override_cell u_cell (
                .portDir(portDirBits[i]),
                .portOut(portOutBits[i]),
                .pullUpAllowed(~pullUpDisable),
                .dirOverrideEn(dirOvEn[i]),
                .dirOverrideVal(dirOvVal[i]),
                .valOverrideEn(valOvEn[i]),
                .valOverrideVal(valOvVal[i]),
                .pullOverrideEn(pullOvEn[i]),
                .pullOverrideVal(pullOvVal[i]),
                .pinDrive(cellDrive[i]),
                .pinValue(cellValue[i]),
                .pinPullUp(cellPull[i])
            );
        end
    endgenerate

    // Pin control is combinational so the clock pin works through reset
    always_comb begin
        pinDrive = cellDrive;
        pinValue = cellValue;
        pinPullUp = cellPull;
    end

    // Input sampling for the peripherals
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serialReceiveData <= 1'b1;
            timer1CaptureIn <= 1'b0;
            spiClockIn <= 1'b0;
        end else begin
            serialReceiveData <= pinInput[PIN_RX_SCK];
            timer1CaptureIn <= pinInput[PIN_RX_SCK];
            spiClockIn <= pinInput[PIN_RX_SCK];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            spiSlaveSelect <= 1'b1;
            spiMosiIn <= 1'b0;
            spiMisoIn <= 1'b0;
            spiSlaveActive <= 1'b0;
        end else begin
            spiSlaveSelect <= pinInput[PIN_TX_MOSI];
            spiMosiIn <= pinInput[PIN_TX_MOSI];
            spiMisoIn <= pinInput[PIN_MISO];
            spiSlaveActive <= (spiRole == SPI_SLAVE) & ~pinInput[PIN_TX_MOSI];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            externalIrqZero <= 1'b0;
        end else begin
            externalIrqZero <= pin6InputOn & pinInput[PIN_EXT_IRQ];
        end
    end

    sequence s_rx_on;
        receiverEnable;
    endsequence

    a_rx_input: assert property (@(posedge clk) disable iff (!rst_n)
        s_rx_on |-> !pinDrive[PIN_RX_SCK])
        else $error("Pin 4 driven while receiver on");
    a_rx_pullup: assert property (@(posedge clk) disable iff (!rst_n)
        s_rx_on |-> pinPullUp[PIN_RX_SCK] == (portOutBits[PIN_RX_SCK] & !pullUpDisable))
        else $error("Pin 4 pull-up wrong under receiver");
    a_sck_slave: assert property (@(posedge clk) disable iff (!rst_n)
        (!receiverEnable && spiRole == SPI_SLAVE) |-> !pinDrive[PIN_RX_SCK])
        else $error("Slave clock pin not input");
    a_tx_drive: assert property (@(posedge clk) disable iff (!rst_n)
        transmitterEnable |-> pinDrive[PIN_TX_MOSI] && pinValue[PIN_TX_MOSI] == transmitData)
        else $error("Transmit pin not driven with data");
    a_ss_active: assert property (@(posedge clk) disable iff (!rst_n)
        (spiRole == SPI_SLAVE && !pinInput[PIN_TX_MOSI]) |=> spiSlaveActive)
        else $error("Slave not active on low select");
    a_mosi_slave: assert property (@(posedge clk) disable iff (!rst_n)
        (!transmitterEnable && spiRole == SPI_SLAVE) |-> !pinDrive[PIN_TX_MOSI])
        else $error("Slave data-in pin driven");
    a_miso_master: assert property (@(posedge clk) disable iff (!rst_n)
        spiRole == SPI_MASTER |-> !pinDrive[PIN_MISO]
            && pinPullUp[PIN_MISO] == (portOutBits[PIN_MISO] & !pullUpDisable))
        else $error("Master data-in pin wrong");
    a_clk_out: assert property (@(posedge clk)
        clockOutputOption |-> pinDrive[PIN_CLK_OUT] && pinValue[PIN_CLK_OUT] == dividedClock)
        else $error("Divided clock not on pin 1");
    a_ordinary_pin: assert property (@(posedge clk) disable iff (!rst_n)
        pinDrive[PIN_SPARE5] == portDirBits[PIN_SPARE5]
            && pinValue[PIN_SPARE0] == portOutBits[PIN_SPARE0])
        else $error("Ordinary pin not following port bits");
    a_irq_zero: assert property (@(posedge clk) disable iff (!rst_n)
        extIrqZeroEnable && pinInput[PIN_EXT_IRQ] |=> externalIrqZero)
        else $error("External interrupt 0 not passed");

    sequence s_spi_slave;
        spiRole == SPI_SLAVE;
    endsequence

    sequence s_spi_master;
        spiRole == SPI_MASTER;
    endsequence

    sequence s_spi_off;
        spiRole == SPI_OFF;
    endsequence

    a_sck_pullup: assert property (@(posedge clk) disable iff (!rst_n)
        (!receiverEnable && spiRole == SPI_SLAVE)
            |-> pinPullUp[PIN_RX_SCK] == (portOutBits[PIN_RX_SCK] & !pullUpDisable))
        else $error("Slave clock pin pull-up wrong");
    a_sck_master: assert property (@(posedge clk) disable iff (!rst_n)
        (!receiverEnable && spiRole == SPI_MASTER)
            |-> pinDrive[PIN_RX_SCK] == portDirBits[PIN_RX_SCK]
            && pinValue[PIN_RX_SCK] == spiClockOut)
        else $error("Master clock pin wrong");
    a_rx_priority: assert property (@(posedge clk) disable iff (!rst_n)
        (receiverEnable && spiRole == SPI_MASTER)
            |-> !pinDrive[PIN_RX_SCK] && pinValue[PIN_RX_SCK] == portOutBits[PIN_RX_SCK])
        else $error("SPI master overrode receiver pin");
    a_rx_sample: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> serialReceiveData == $past(pinInput[PIN_RX_SCK]))
        else $error("Receive data not sampled from pin 4");
    a_mosi_pullup: assert property (@(posedge clk) disable iff (!rst_n)
        (!transmitterEnable && spiRole == SPI_SLAVE)
            |-> pinPullUp[PIN_TX_MOSI] == (portOutBits[PIN_TX_MOSI] & !pullUpDisable))
        else $error("Slave data-in pin pull-up wrong");
    a_mosi_master: assert property (@(posedge clk) disable iff (!rst_n)
        (!transmitterEnable && spiRole == SPI_MASTER)
            |-> pinDrive[PIN_TX_MOSI] == portDirBits[PIN_TX_MOSI]
            && pinValue[PIN_TX_MOSI] == spiMosiOut)
        else $error("Master data-out pin wrong");
    a_tx_priority: assert property (@(posedge clk) disable iff (!rst_n)
        (transmitterEnable && spiRole != SPI_OFF)
            |-> pinDrive[PIN_TX_MOSI] && pinValue[PIN_TX_MOSI] == transmitData)
        else $error("SPI overrode transmit pin");
    a_timer0_out: assert property (@(posedge clk) disable iff (!rst_n)
        (!transmitterEnable && spiRole == SPI_OFF) |-> pinValue[PIN_TX_MOSI]
            == (timer0CompareEn ? timer0CompareA : portOutBits[PIN_TX_MOSI]))
        else $error("Timer 0 output gating wrong");
    a_miso_slave: assert property (@(posedge clk) disable iff (!rst_n)
        s_spi_slave |-> pinDrive[PIN_MISO] == portDirBits[PIN_MISO]
            && pinValue[PIN_MISO] == spiMisoOut)
        else $error("Slave data-out pin wrong");
    a_timer1_out: assert property (@(posedge clk) disable iff (!rst_n)
        s_spi_off |-> pinValue[PIN_MISO]
            == (timer1CompareEn ? timer1CompareA : portOutBits[PIN_MISO]))
        else $error("Timer 1 output gating wrong");
    a_master_inactive: assert property (@(posedge clk) disable iff (!rst_n)
        s_spi_master |=> !spiSlaveActive)
        else $error("Slave active while master");
    a_ss_idle: assert property (@(posedge clk) disable iff (!rst_n)
        pinInput[PIN_TX_MOSI] |=> !spiSlaveActive)
        else $error("Slave active with select high");
    a_clk_reset: assert property (@(posedge clk)
        (!rst_n && clockOutputOption)
            |-> pinDrive[PIN_CLK_OUT] && pinValue[PIN_CLK_OUT] == dividedClock)
        else $error("Divided clock lost during reset");
    a_irq_gated: assert property (@(posedge clk) disable iff (!rst_n)
        (!extIrqZeroEnable && adc3DigitalOff) |=> !externalIrqZero)
        else $error("External interrupt 0 passed while input off");
    a_pin6_plain: assert property (@(posedge clk) disable iff (!rst_n)
        pinDrive[PIN_EXT_IRQ] == portDirBits[PIN_EXT_IRQ]
            && pinValue[PIN_EXT_IRQ] == portOutBits[PIN_EXT_IRQ])
        else $error("Pin 6 not following port bits");
endmodule

// *** tb/port_d_pin_world.sv ***
// External pin world: resolves the level seen on each port D pin
`timescale 1ns/10ps
module port_d_pin_world (
    input wire logic clk, // System clock
    input wire logic [6:0] pinDrive, // Mux output enables
    input wire logic [6:0] pinValue, // Mux output levels
    input wire logic [6:0] pinPullUp, // Mux pull-up enables
    input wire logic [6:0] extDrive, // Pins driven from outside
    input wire logic [6:0] extLevel, // Levels driven from outside
    output logic [6:0] pinInput // Resolved pin levels
);
    logic floatPat;
    initial floatPat = 1'b0;
    // Floating pins wander, so no stale level passes for a real one
    always @(posedge clk) begin
        floatPat <= ~floatPat;
    end
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (pinDrive[i]) begin
                pinInput[i] = pinValue[i];
            end else if (extDrive[i]) begin
                pinInput[i] = extLevel[i];
            end else if (pinPullUp[i]) begin
                pinInput[i] = 1'b1;
            end else begin
                pinInput[i] = floatPat;
            end
        end
    end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the port D alternate function mux
`timescale 1ns/10ps
module testbench;
    import port_d_mux_pkg::*;
    logic clk, rst_n, pullUpDisable, receiverEnable, transmitterEnable, transmitData;
    logic spiEnable, spiMaster, spiPinSelect, spiClockOut, spiMosiOut, spiMisoOut;
    logic timer0CompareEn, timer0CompareA, timer1CompareEn, timer1CompareA;
    logic clockOutputOption, dividedClock, extIrqZeroEnable, adc3DigitalOff;
    logic serialReceiveData, spiClockIn, spiSlaveSelect, spiMosiIn, spiMisoIn;
    logic timer1CaptureIn, externalIrqZero, spiSlaveActive;
    logic [6:0] portDirBits, portOutBits, pinInput, pinDrive, pinValue, pinPullUp;
    logic [6:0] extDrive, extLevel;
    int n_mismatch = 0;
    int cmp_count = 0;
    port_d_alternate_function_mux i_port_d_alternate_function_mux (.*);
    port_d_pin_world i_port_d_pin_world (.*);
    task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic idle();
        {pullUpDisable, receiverEnable, transmitterEnable, transmitData} = '0;
        {spiEnable, spiMaster, spiPinSelect, spiClockOut, spiMosiOut, spiMisoOut} = '0;
        {timer0CompareEn, timer0CompareA, timer1CompareEn, timer1CompareA} = '0;
        {clockOutputOption, dividedClock, extIrqZeroEnable, adc3DigitalOff} = '0;
        {portDirBits, portOutBits, extDrive, extLevel} = '0;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #40000;
        n_mismatch++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        idle();
        clockOutputOption = 1'b1;
        repeat (8) begin
            dividedClock = ~dividedClock;
            #1;
            chk("clkout drive", 7'h02, pinDrive & 7'h02);
            chk("clkout level", {5'h00, dividedClock, 1'b0}, pinValue & 7'h02);
            tick();
        end
        chk("rx data rst", 7'h01, serialReceiveData);
        chk("ss rst", 7'h01, spiSlaveSelect);
        chk("active rst", 7'h00, spiSlaveActive);
        chk("spi in rst", 7'h00, {spiClockIn, spiMosiIn, spiMisoIn});
        chk("cap irq rst", 7'h00, {timer1CaptureIn, externalIrqZero});
        rst_n = 1'b1;
        idle();
        portDirBits = 7'h55;
        portOutBits = 7'h2a;
        tick();
        chk("plain drive", 7'h55, pinDrive);
        chk("plain value", 7'h2a, pinValue);
        chk("plain pull", 7'h2a, pinPullUp);
        pullUpDisable = 1'b1;
        tick();
        chk("pull off", 7'h00, pinPullUp);
        idle();
        // Receiver and SPI master both claim pin 4
        {receiverEnable, spiEnable, spiMaster, spiPinSelect} = 4'hf;
        {portDirBits, portOutBits, extDrive} = {7'h10, 7'h10, 7'h10};
        tick();
        chk("rx drive", 7'h00, pinDrive & 7'h10);
        chk("rx pull", 7'h10, pinPullUp & 7'h10);
        chk("rx data", 7'h00, serialReceiveData);
        portOutBits = 7'h00;
        tick();
        chk("rx pull low", 7'h00, pinPullUp & 7'h10);
        for (int m = 0; m < 2; m++) begin
            idle();
            {spiEnable, spiPinSelect, spiMaster} = {2'b11, m[0]};
            {portDirBits, portOutBits} = {7'h1c, 7'h1c};
            tick();
            chk("spi drive", m ? 7'h18 : 7'h04, pinDrive & 7'h1c);
            chk("spi pull", m ? 7'h04 : 7'h18, pinPullUp & 7'h1c);
            chk("spi value", 7'h00, pinValue & (m ? 7'h18 : 7'h04));
            portDirBits = 7'h00;
            {extDrive, extLevel} = {7'h08, 7'h00};
            tick();
            chk("spi dir", 7'h00, pinDrive & 7'h1c);
            tick();
            chk("slave active", {6'h00, ~m[0]}, spiSlaveActive);
            chk("ss pin", 7'h00, spiSlaveSelect);
            chk("spi pins in", 7'h07, {spiClockIn, timer1CaptureIn, spiMisoIn});
            extLevel = 7'h08;
            tick();
            tick();
            chk("slave idle", 7'h00, spiSlaveActive);
            chk("mosi in", 7'h01, spiMosiIn);
        end
        idle();
        {transmitterEnable, spiEnable, spiPinSelect} = 3'h7;
        {timer0CompareEn, timer0CompareA} = 2'b11;
        for (int b = 0; b < 2; b++) begin
            transmitData = b[0];
            tick();
            chk("tx drive", 7'h08, pinDrive & 7'h08);
            chk("tx value", {3'h0, b[0], 3'h0}, pinValue & 7'h08);
        end
        idle();
        portDirBits = 7'h0c;
        {timer0CompareEn, timer1CompareEn} = 2'b11;
        for (int a = 0; a < 2; a++) begin
            {timer0CompareA, timer1CompareA} = {a[0], ~a[0]};
            tick();
            chk("timer value", {3'h0, a[0], ~a[0], 2'h0}, pinValue & 7'h0c);
        end
        idle();
        clockOutputOption = 1'b1;
        // Last two passes hold reset to show the clock pin keeps running
        for (int d = 0; d < 4; d++) begin
            rst_n = (d < 2);
            dividedClock = d[0];
            tick();
            chk("clkout", {5'h00, d[0], 1'b0}, pinValue & pinDrive & 7'h02);
            chk("clkout en", 7'h02, pinDrive & 7'h02);
        end
        chk("rx data rst2", 7'h01, serialReceiveData);
        chk("ss rst2", 7'h01, spiSlaveSelect);
        rst_n = 1'b1;
        idle();
        {adc3DigitalOff, extIrqZeroEnable} = 2'b11;
        {extDrive, extLevel} = {7'h40, 7'h40};
        tick();
        tick();
        chk("irq in", 7'h01, externalIrqZero);
        extIrqZeroEnable = 1'b0;
        tick();
        tick();
        chk("irq gated", 7'h00, externalIrqZero);
        final_report();
    end
endmodule
